// File: spc_pkg.sv
package spc_pkg;

  // ----------------------------------------------------------------
  // Sizes and field positions
  // ----------------------------------------------------------------
  localparam int NUM_CS = 4;
  localparam int DATA_W = 16;
  localparam int FINAL_BIT = 24;
  localparam int PCS_LSB = 16;
  localparam logic [4:0] MIN_BITS = 5'h08;
  localparam logic [3:0] BITS_MAX = 4'h8;
  localparam logic [7:0] DIV_ONE = 8'h01;

  // ----------------------------------------------------------------
  // Per-select configuration
  // ----------------------------------------------------------------
  // Frame width is MIN_BITS + bits, so 0 means 8 bits and 8 means 16 bits
  typedef struct packed {
    logic [7:0] divider;
    logic clock_polarity;
    logic clock_phase_inverse;
    logic [3:0] bits;
    logic hold;
  } spc_cfg_t;

  localparam spc_cfg_t CFG_RST = '{divider: 8'h00, clock_polarity: 1'b0, clock_phase_inverse: 1'b0, bits: 4'h0, hold: 1'b0};

  // Decoded transmit word
  typedef struct packed {
    logic final_xfer;
    logic [1:0] pcs;
    logic [DATA_W-1:0] data;
  } spc_word_t;

  localparam spc_word_t WORD_RST = '{final_xfer: 1'b0, pcs: 2'h0, data: 16'h0000};

  typedef enum logic [1:0] {
    S_IDLE,
    S_LEAD,
    S_SHIFT
  } spc_state_t;

endpackage

// File: spc_clkdiv.sv
`timescale 1ns/10ps
module spc_clkdiv (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic [7:0] divider_i,
  output logic tick_o
);

  logic [7:0] cnt_q;
  logic [7:0] last_w;

  // A divider of zero behaves as one so the serial clock never stalls
  assign last_w = (divider_i == 8'h00) ? 8'h00 : divider_i - 8'h01;
  assign tick_o = run_i && (cnt_q == last_w);

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt_q <= 8'h00;
    end else if (ce_i) begin
      if (!run_i || tick_o) begin
        cnt_q <= 8'h00;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

endmodule

// File: spc_controller.sv
`timescale 1ns/10ps
// How it works
// - One soft reset leaves the sequencer faulty so the serial clock starts before the select is asserted.
// - With hold-select and divider 1, a second word to the held select after an idle gap keeps transmit-ready low and is sent again and again.
// - In fixed select with hold-select under DMA, a pending word with bit 24 set drops the select once transmit-empty is set.
// - In master operation the serial clock may toggle before the first transfer has started.
// - In fixed select the DMA transfer size follows the width of select 0 whatever select is active.
// - With divider 1 an odd frame width gives one extra serial clock pulse; even widths get one only in the polarity-1 case below.
// - In slave operation a disable command is ignored and the block keeps running.
// - With polarity 1 and inverted phase 0, a divider-1 transfer after a slower one gets one extra pulse.
module spc_controller #(
  parameter int NUM_CS = spc_pkg::NUM_CS
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic soft_reset_bit_i,
  input wire logic enable_i,
  input wire logic disable_i,
  input wire logic master_select_bit_i,
  input wire logic fixed_select_i,
  input wire logic [1:0] fixed_cs_i,
  input wire logic dma_mode_i,
  input wire logic cfg_we_i,
  input wire logic [1:0] cfg_idx_i,
  input wire spc_pkg::spc_cfg_t cfg_i,
  input wire logic tdr_we_i,
  input wire logic [31:0] transmit_data_reg_i,
  input wire logic rx_read_i,
  input wire logic miso_i,
  input wire logic sclk_in_i,
  input wire logic ss_n_i,
  input wire logic mosi_in_i,
  output logic serial_clock_pin_o,
  output logic data_out_o,
  output logic [NUM_CS-1:0] cs_n_o,
  output logic tx_ready_o,
  output logic transmit_empty_flag_o,
  output logic [spc_pkg::DATA_W-1:0] rx_data_o,
  output logic rx_ready_o,
  output logic dma_halfword_o,
  output logic enabled_o
);

  if (NUM_CS < 1 || NUM_CS > 4) begin : g_bad_num_cs
    $error("NUM_CS must be 1 to 4");
  end

  function automatic logic [NUM_CS-1:0] cs_onehot(input logic [1:0] idx);
    cs_onehot = '0;
    if (int'(idx) < NUM_CS) begin
      cs_onehot[idx] = 1'b1;
    end
  endfunction

  function automatic logic [4:0] width_of(input spc_pkg::spc_cfg_t c);
    width_of = spc_pkg::MIN_BITS + {1'b0, c.bits};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  spc_pkg::spc_cfg_t cfg_q [NUM_CS];
  spc_pkg::spc_cfg_t act_cfg_q;
  spc_pkg::spc_word_t tdr_q;
  spc_pkg::spc_state_t state_q;
  logic en_q, tdr_full_q, cs_held_q, misseq_q, late_cs_q, prev_slow_q, pretoggle_q, glitch_q, sclk_q;
  logic [1:0] act_cs_q;
  logic [5:0] edge_cnt_q;
  logic [4:0] npulse_q;
  logic [spc_pkg::DATA_W-1:0] shreg_q, sl_shreg_q;
  logic [4:0] sl_cnt_q;
  logic sl_sclk_prev_q, miso_bit_q;

  logic [1:0] next_cs_w;
  logic tick_w, start_w, done_w, div1_w, bug3_w, extra_w, r5_rel_w, slave_w;
  logic [4:0] nbits_w;

  assign slave_w = !master_select_bit_i;
  assign next_cs_w = fixed_select_i ? fixed_cs_i : tdr_q.pcs;
  assign div1_w = cfg_q[next_cs_w].divider <= spc_pkg::DIV_ONE;
  assign nbits_w = width_of(cfg_q[next_cs_w]);
  assign start_w = ce_i && !soft_reset_bit_i && state_q == spc_pkg::S_IDLE && en_q && master_select_bit_i
                   && tdr_full_q && !r5_rel_w;
  // Held select reused after an idle gap with the fastest divider
  assign bug3_w = cfg_q[next_cs_w].hold && div1_w && cs_held_q && act_cs_q == next_cs_w;
  assign extra_w = (div1_w && nbits_w[0])
                   || (div1_w && prev_slow_q && cfg_q[next_cs_w].clock_polarity && !cfg_q[next_cs_w].clock_phase_inverse);
  // The flag is taken from the word as it is written, before that word has been sent
  assign r5_rel_w = fixed_select_i && dma_mode_i && cs_held_q && act_cfg_q.hold && transmit_empty_flag_o
                    && tdr_we_i && transmit_data_reg_i[spc_pkg::FINAL_BIT];
  assign done_w = state_q == spc_pkg::S_SHIFT && tick_w && edge_cnt_q == {npulse_q, 1'b0} - 6'h01;

  spc_clkdiv spc_clkdiv_i (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .run_i(state_q != spc_pkg::S_IDLE),
    .divider_i(act_cfg_q.divider),
    .tick_o(tick_w)
  );

  // ----------------------------------------------------------------
  // Configuration, enable and soft reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i || (ce_i && soft_reset_bit_i)) begin
      for (int i = 0; i < NUM_CS; i++) begin
        cfg_q[i] <= spc_pkg::CFG_RST;
      end
    end else if (ce_i && cfg_we_i && int'(cfg_idx_i) < NUM_CS) begin
      cfg_q[cfg_idx_i] <= cfg_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      en_q <= 1'b0;
    end else if (ce_i) begin
      if (soft_reset_bit_i) begin
        en_q <= 1'b0;
      end else if (enable_i) begin
        en_q <= 1'b1;
      end else if (disable_i && !slave_w) begin
        en_q <= 1'b0;
      end
    end
  end

  // Alternates on each soft reset, so only an even run of writes leaves it clean
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      misseq_q <= 1'b0;
    end else if (ce_i && soft_reset_bit_i) begin
      misseq_q <= !misseq_q;
    end
  end

  // A select written before the master bit leaves a stray clock edge armed
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pretoggle_q <= 1'b0;
      glitch_q <= 1'b0;
    end else if (ce_i) begin
      glitch_q <= pretoggle_q && master_select_bit_i && state_q == spc_pkg::S_IDLE;
      if (cfg_we_i && !master_select_bit_i) begin
        pretoggle_q <= 1'b1;
      end else if (glitch_q) begin
        pretoggle_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit holding register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      tdr_q <= spc_pkg::WORD_RST;
      tdr_full_q <= 1'b0;
    end else if (ce_i) begin
      if (soft_reset_bit_i) begin
        tdr_full_q <= 1'b0;
      end else if (tdr_we_i) begin
        tdr_q.final_xfer <= transmit_data_reg_i[spc_pkg::FINAL_BIT];
        tdr_q.pcs <= transmit_data_reg_i[spc_pkg::PCS_LSB+1:spc_pkg::PCS_LSB];
        tdr_q.data <= transmit_data_reg_i[spc_pkg::DATA_W-1:0];
        tdr_full_q <= 1'b1;
      end else if (start_w && !bug3_w) begin
        tdr_full_q <= 1'b0;
      end
    end
  end

  assign tx_ready_o = !tdr_full_q;
  assign transmit_empty_flag_o = !tdr_full_q && state_q == spc_pkg::S_IDLE;

  // ----------------------------------------------------------------
  // Master sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_q <= spc_pkg::S_IDLE;
      act_cfg_q <= spc_pkg::CFG_RST;
      act_cs_q <= 2'h0;
      npulse_q <= spc_pkg::MIN_BITS;
      late_cs_q <= 1'b0;
      prev_slow_q <= 1'b0;
    end else if (ce_i) begin
      if (soft_reset_bit_i) begin
        state_q <= spc_pkg::S_IDLE;
      end else if (start_w) begin
        act_cfg_q <= cfg_q[next_cs_w];
        act_cs_q <= next_cs_w;
        npulse_q <= nbits_w + {4'h0, extra_w};
        prev_slow_q <= !div1_w;
        late_cs_q <= misseq_q;
        state_q <= misseq_q ? spc_pkg::S_SHIFT : spc_pkg::S_LEAD;
      end else if (state_q == spc_pkg::S_LEAD && tick_w) begin
        state_q <= spc_pkg::S_SHIFT;
      end else if (done_w) begin
        state_q <= spc_pkg::S_IDLE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cs_held_q <= 1'b0;
    end else if (ce_i) begin
      if (soft_reset_bit_i || r5_rel_w) begin
        cs_held_q <= 1'b0;
      end else if (start_w && act_cs_q != next_cs_w) begin
        cs_held_q <= 1'b0;
      end else if (done_w) begin
        cs_held_q <= act_cfg_q.hold && !tdr_q.final_xfer;
      end
    end
  end

  // Sample on the first edge of a pulse, shift on the second
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      edge_cnt_q <= 6'h00;
      sclk_q <= 1'b0;
      shreg_q <= '0;
      miso_bit_q <= 1'b0;
    end else if (ce_i) begin
      if (start_w) begin
        edge_cnt_q <= 6'h00;
        sclk_q <= cfg_q[next_cs_w].clock_polarity;
        shreg_q <= tdr_q.data << (5'h10 - nbits_w);
      end else if (state_q == spc_pkg::S_SHIFT && tick_w) begin
        edge_cnt_q <= edge_cnt_q + 6'h01;
        sclk_q <= !sclk_q;
        if (!edge_cnt_q[0]) begin
          miso_bit_q <= miso_i;
        end else begin
          shreg_q <= {shreg_q[spc_pkg::DATA_W-2:0], miso_bit_q};
        end
      end else if (state_q == spc_pkg::S_IDLE) begin
        sclk_q <= act_cfg_q.clock_polarity;
      end
    end
  end

  assign serial_clock_pin_o = sclk_q ^ glitch_q;
  assign cs_n_o = ((state_q != spc_pkg::S_IDLE || cs_held_q)
                  && !(late_cs_q && state_q == spc_pkg::S_SHIFT && edge_cnt_q < 6'h02))
                  ? ~cs_onehot(act_cs_q) : '1;
  assign data_out_o = slave_w ? sl_shreg_q[spc_pkg::DATA_W-1] : shreg_q[spc_pkg::DATA_W-1];
  assign dma_halfword_o = fixed_select_i ? (cfg_q[0].bits != 4'h0)
                                         : (cfg_q[next_cs_w].bits != 4'h0);
  assign enabled_o = en_q;

  // ----------------------------------------------------------------
  // Slave receiver, framed by the settings of select 0
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sl_sclk_prev_q <= 1'b0;
      sl_cnt_q <= 5'h00;
      sl_shreg_q <= '0;
    end else if (ce_i) begin
      sl_sclk_prev_q <= sclk_in_i;
      if (soft_reset_bit_i || ss_n_i || !slave_w || !en_q) begin
        sl_cnt_q <= 5'h00;
      end else if (sclk_in_i && !sl_sclk_prev_q) begin
        sl_shreg_q <= {sl_shreg_q[spc_pkg::DATA_W-2:0], mosi_in_i};
        sl_cnt_q <= (sl_cnt_q + 5'h01 == width_of(cfg_q[0])) ? 5'h00 : sl_cnt_q + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive data; a new word wins over a read in the same cycle
  // ----------------------------------------------------------------
  logic sl_done_w;
  assign sl_done_w = slave_w && en_q && !ss_n_i && sclk_in_i && !sl_sclk_prev_q
                     && sl_cnt_q + 5'h01 == width_of(cfg_q[0]);

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rx_data_o <= '0;
      rx_ready_o <= 1'b0;
    end else if (ce_i) begin
      if (soft_reset_bit_i) begin
        rx_ready_o <= 1'b0;
      end else if (done_w) begin
        rx_data_o <= {shreg_q[spc_pkg::DATA_W-2:0], miso_bit_q};
        rx_ready_o <= 1'b1;
      end else if (sl_done_w) begin
        rx_data_o <= {sl_shreg_q[spc_pkg::DATA_W-2:0], mosi_in_i};
        rx_ready_o <= 1'b1;
      end else if (rx_read_i) begin
        rx_ready_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_late_select;
    @(posedge clk_i) disable iff (!nrst_i) (start_w && misseq_q && !cs_held_q) |=> (&cs_n_o) [*2];
  endproperty
  a_late_select: assert property (p_late_select) else $error("select asserted with clock after single reset");

  property p_double_send;
    @(posedge clk_i) disable iff (!nrst_i) (start_w && bug3_w && !tdr_we_i) |=> !tx_ready_o;
  endproperty
  a_double_send: assert property (p_double_send) else $error("transmit ready rose on held divider-1 word");

  property p_final_release;
    @(posedge clk_i) disable iff (!nrst_i) (ce_i && !soft_reset_bit_i && r5_rel_w) |=> (&cs_n_o) && !cs_held_q;
  endproperty
  a_final_release: assert property (p_final_release) else $error("select not dropped on final flag");

  property p_stray_edge;
    @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && pretoggle_q && !glitch_q && master_select_bit_i && state_q == spc_pkg::S_IDLE)
      |=> serial_clock_pin_o != sclk_q;
  endproperty
  a_stray_edge: assert property (p_stray_edge) else $error("no stray clock edge before first transfer");

  property p_dma_size;
    @(posedge clk_i) disable iff (!nrst_i) fixed_select_i |-> dma_halfword_o == (cfg_q[0].bits != 4'h0);
  endproperty
  a_dma_size: assert property (p_dma_size) else $error("DMA size not taken from select 0");

  property p_odd_pulse;
    @(posedge clk_i) disable iff (!nrst_i)
      (start_w && div1_w && nbits_w[0]) |=> npulse_q == $past(nbits_w) + 5'h01;
  endproperty
  a_odd_pulse: assert property (p_odd_pulse) else $error("odd width at divider 1 lacks extra pulse");

  property p_slave_disable;
    @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && en_q && slave_w && disable_i && !soft_reset_bit_i) |=> en_q;
  endproperty
  a_slave_disable: assert property (p_slave_disable) else $error("slave stopped by disable");

  property p_mixed_div;
    @(posedge clk_i) disable iff (!nrst_i)
      (start_w && div1_w && prev_slow_q && cfg_q[next_cs_w].clock_polarity && !cfg_q[next_cs_w].clock_phase_inverse)
      |=> npulse_q == $past(nbits_w) + 5'h01;
  endproperty
  a_mixed_div: assert property (p_mixed_div) else $error("no extra pulse after slower select");

  property p_per_select;
    @(posedge clk_i) disable iff (!nrst_i)
      start_w |=> act_cfg_q == $past(cfg_q[next_cs_w]) && act_cs_q == $past(next_cs_w);
  endproperty
  a_per_select: assert property (p_per_select) else $error("transfer not using its select settings");

endmodule

// File: spc_periph_model.sv
`timescale 1ns/10ps
module spc_periph_model #(
  parameter logic [15:0] REPLY = 16'hA5C3
) (
  input wire logic clk_i,
  input wire logic sclk_i,
  input wire logic mosi_i,
  input wire logic [3:0] cs_n_i,
  output logic miso_o,
  output logic [15:0] rx_word_o,
  output int edges_o,
  output int stray_o
);
  logic sel_q = 1'b0;
  logic sclk_q = 1'b0;
  logic noise_q = 1'b0;
  logic [15:0] sh_q = 16'h0000;

  // A deselected line keeps changing, so a stale bit is never taken for data
  assign miso_o = (&cs_n_i) ? noise_q : sh_q[15];

  // Edges are seen one cycle late, which keeps the count free of same-edge races
  // A select that has just risen still owns the last edge launched with it
  always @(posedge clk_i) begin
    noise_q <= ~noise_q;
    sel_q <= ~&cs_n_i;
    sclk_q <= sclk_i;
    if (&cs_n_i && !sel_q) begin
      sh_q <= REPLY;
      if (sclk_i != sclk_q) begin
        stray_o <= stray_o + 1;
      end
    end else if (sclk_i != sclk_q) begin
      edges_o <= (sel_q ? edges_o : 0) + 1;
      if (!sel_q || !edges_o[0]) begin
        rx_word_o <= {rx_word_o[14:0], mosi_i};
        sh_q <= {sh_q[14:0], 1'b0};
      end
    end else if (!sel_q) begin
      edges_o <= 0;
    end
  end
endmodule

// File: spc_controller_tb_top.sv
`timescale 1ns/10ps
module spc_controller_tb_top;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  localparam logic [15:0] REPLY = 16'hA5C3;
  localparam logic [7:0] SL_BYTE = 8'h96;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic soft_rst = 1'b0;
  logic en = 1'b0;
  logic dis = 1'b0;
  logic master_select_bit = 1'b1;
  logic fixed = 1'b0;
  logic [1:0] fixed_cs = 2'h0;
  logic dma = 1'b0;
  logic cfg_we = 1'b0;
  logic [1:0] cfg_idx = 2'h0;
  spc_pkg::spc_cfg_t cfg = spc_pkg::CFG_RST;
  logic tdr_we = 1'b0;
  logic [31:0] tdr = 32'h00000000;
  logic rx_read = 1'b0;
  logic sclk_in = 1'b0;
  logic ss_n = 1'b1;
  logic mosi_in = 1'b0;
  logic miso, sclk, mosi, tx_ready, tx_empty, rx_ready, dma_hw, enabled;
  logic [3:0] cs_n;
  logic [15:0] rx_data;
  logic [15:0] m_rx;
  int m_edges, m_stray, fail_count, checks, cycles;

  always #5 clk = ~clk;

  spc_controller #(.NUM_CS(4)) spc_controller_i (.clk_i(clk), .nrst_i(nrst), .ce_i(1'b1),
    .soft_reset_bit_i(soft_rst), .enable_i(en), .disable_i(dis), .master_select_bit_i(master_select_bit),
    .fixed_select_i(fixed), .fixed_cs_i(fixed_cs), .dma_mode_i(dma), .cfg_we_i(cfg_we), .cfg_idx_i(cfg_idx),
    .cfg_i(cfg), .tdr_we_i(tdr_we), .transmit_data_reg_i(tdr), .rx_read_i(rx_read), .miso_i(miso),
    .sclk_in_i(sclk_in), .ss_n_i(ss_n), .mosi_in_i(mosi_in), .serial_clock_pin_o(sclk), .data_out_o(mosi),
    .cs_n_o(cs_n), .tx_ready_o(tx_ready), .transmit_empty_flag_o(tx_empty), .rx_data_o(rx_data),
    .rx_ready_o(rx_ready), .dma_halfword_o(dma_hw), .enabled_o(enabled));

  spc_periph_model #(.REPLY(REPLY)) spc_periph_model_i (.clk_i(clk), .sclk_i(sclk), .mosi_i(mosi),
    .cs_n_i(cs_n), .miso_o(miso), .rx_word_o(m_rx), .edges_o(m_edges), .stray_o(m_stray));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] mask(input int w);
    return 16'hFFFF >> (16 - w);
  endfunction

  task automatic srst(input int n);
    repeat (n) begin
      @(posedge clk);
      soft_rst <= 1'b1;
      @(posedge clk);
      soft_rst <= 1'b0;
    end
  endtask

  task automatic prep(input int n);
    srst(n);
    @(posedge clk);
    en <= 1'b1;
    @(posedge clk);
    en <= 1'b0;
  endtask

  task automatic setc(input logic [1:0] idx, input logic [7:0] dv, input logic pol, input logic [3:0] b,
                      input logic hd);
    @(posedge clk);
    cfg_we <= 1'b1;
    cfg_idx <= idx;
    cfg <= '{divider: dv, clock_polarity: pol, clock_phase_inverse: 1'b0, bits: b, hold: hd};
    @(posedge clk);
    cfg_we <= 1'b0;
  endtask

  task automatic xfer(input logic [1:0] cs, input logic [15:0] d, input logic fin);
    int n;
    n = 0;
    @(posedge clk);
    tdr_we <= 1'b1;
    tdr <= {7'h00, fin, 6'h00, cs, d};
    @(posedge clk);
    tdr_we <= 1'b0;
    while (rx_ready !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    check(n < 3000, 1'b1);
    rx_read <= 1'b1;
    @(posedge clk);
    rx_read <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_seq();
    int s;
    prep(2);
    setc(2'h0, 8'h01, 1'b0, 4'h0, 1'b0);
    s = m_stray;
    xfer(2'h0, 16'h3C00, 1'b0);
    check(m_stray - s, 0);
    prep(1);
    setc(2'h0, 8'h01, 1'b0, 4'h0, 1'b0);
    s = m_stray;
    xfer(2'h0, 16'h3C00, 1'b0);
    check(m_stray > s, 1'b1);
    prep(1);
  endtask

  task automatic t_sel();
    logic [7:0] dv [4] = '{8'h02, 8'h03, 8'h04, 8'h02};
    logic [3:0] bw [4] = '{4'h0, 4'h2, 4'h5, 4'h8};
    int w;
    for (int i = 0; i < 4; i++) setc(2'(i), dv[i], 1'b0, bw[i], 1'b0);
    for (int i = 0; i < 4; i++) begin
      w = 8 + bw[i];
      xfer(2'(i), 16'hC35A, 1'b0);
      check(m_edges, 2 * w);
      check(m_rx & mask(w), 16'hC35A & mask(w));
      check(rx_data & mask(w), REPLY >> (16 - w));
      check(tx_empty, 1'b1);
    end
  endtask

  task automatic t_odd();
    int w;
    for (int b = 0; b <= 8; b++) begin
      w = 8 + b;
      setc(2'h0, 8'h01, 1'b0, 4'(b), 1'b0);
      xfer(2'h0, 16'h5A5A, 1'b0);
      check(m_edges, 2 * (w + w % 2));
    end
  endtask

  // Mixing divider 1 with a slower select here is deliberate
  task automatic t_fast();
    setc(2'h0, 8'h03, 1'b1, 4'h0, 1'b0);
    setc(2'h1, 8'h01, 1'b1, 4'h0, 1'b0);
    xfer(2'h0, 16'h1234, 1'b0);
    xfer(2'h0, 16'h1234, 1'b0);
    check(m_edges, 16);
    xfer(2'h1, 16'h1234, 1'b0);
    check(m_edges, 18);
    xfer(2'h1, 16'h1234, 1'b0);
    check(m_edges, 16);
  endtask

  task automatic t_dma();
    fixed <= 1'b1;
    fixed_cs <= 2'h1;
    setc(2'h0, 8'h02, 1'b0, 4'h2, 1'b0);
    setc(2'h1, 8'h02, 1'b0, 4'h0, 1'b0);
    @(posedge clk);
    check(dma_hw, 1'b1);
    setc(2'h0, 8'h02, 1'b0, 4'h0, 1'b0);
    @(posedge clk);
    check(dma_hw, 1'b0);
  endtask

  task automatic t_final();
    prep(2);
    fixed_cs <= 2'h0;
    dma <= 1'b1;
    setc(2'h0, 8'h02, 1'b0, 4'h0, 1'b1);
    xfer(2'h0, 16'h0F0F, 1'b0);
    check(cs_n[0], 1'b0);
    @(posedge clk);
    tdr_we <= 1'b1;
    tdr <= {7'h00, 1'b1, 6'h00, 2'h0, 16'h0F0F};
    @(posedge clk);
    tdr_we <= 1'b0;
    @(posedge clk);
    check(cs_n[0], 1'b1);
    repeat (60) @(posedge clk);
    check(rx_ready, 1'b1);
    rx_read <= 1'b1;
    @(posedge clk);
    rx_read <= 1'b0;
    check(cs_n[0], 1'b1);
    fixed <= 1'b0;
    dma <= 1'b0;
  endtask

  // Hold with divider 1 is set on purpose to expose the stuck ready flag
  task automatic t_stale();
    prep(2);
    setc(2'h0, 8'h01, 1'b0, 4'h0, 1'b1);
    xfer(2'h0, 16'hAAAA, 1'b0);
    xfer(2'h0, 16'h5555, 1'b0);
    check(tx_ready, 1'b0);
    prep(2);
  endtask

  task automatic t_stray();
    int s;
    master_select_bit <= 1'b0;
    setc(2'h0, 8'h02, 1'b0, 4'h0, 1'b0);
    s = m_stray;
    master_select_bit <= 1'b1;
    repeat (6) @(posedge clk);
    check(m_stray > s, 1'b1);
  endtask

  task automatic t_slave();
    master_select_bit <= 1'b0;
    prep(2);
    dis <= 1'b1;
    @(posedge clk);
    dis <= 1'b0;
    @(posedge clk);
    check(enabled, 1'b1);
    ss_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi_in <= SL_BYTE[i];
      repeat (2) @(posedge clk);
      sclk_in <= 1'b1;
      repeat (2) @(posedge clk);
      sclk_in <= 1'b0;
    end
    repeat (2) @(posedge clk);
    ss_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(rx_ready, 1'b1);
    check(rx_data[7:0], SL_BYTE);
    rx_read <= 1'b1;
    @(posedge clk);
    rx_read <= 1'b0;
    srst(2);
    @(posedge clk);
    check(enabled, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    if (fail_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      report_and_stop();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_seq();
    t_sel();
    t_odd();
    t_fast();
    t_dma();
    t_final();
    t_stale();
    t_stray();
    t_slave();
    report_and_stop();
  end
endmodule
